// ### design/fdps_pkg.sv
package fdps_pkg;
  // register byte addresses on the ahb-lite slave
  localparam logic [7:0] FDPS_PHASE_ADDR = 8'h00;
  localparam logic [7:0] FDPS_SPREAD_ADDR = 8'h04;
  localparam logic [7:0] FDPS_STATUS_ADDR = 8'h08;
  // phase register fields
  localparam int FDPS_APPLY_NOW_BIT = 15;
  localparam int FDPS_APPLY_SYNC_BIT = 14;
  localparam int FDPS_SLOW_BIT = 13;
  localparam int FDPS_GROUP_HI = 11;
  localparam int FDPS_GROUP_LO = 10;
  localparam int FDPS_PHASE_HI = 9;
  localparam int FDPS_PHASE_W = 10;
  localparam logic [9:0] FDPS_PHASE_RESET = 10'h3f0;
  localparam logic [1:0] FDPS_GROUP_RESET = 2'h0;
  localparam logic FDPS_APPLY_SYNC_RESET = 1'b1;
  // spread register fields
  localparam int FDPS_SSC_EN_BIT = 31;
  localparam int FDPS_SSC_MODE_BIT = 30;
  localparam int FDPS_AMPL_HI = 23;
  localparam int FDPS_AMPL_LO = 16;
  localparam int FDPS_STEP_HI = 15;
  localparam logic [7:0] FDPS_AMPL_RESET = 8'h51;
  localparam logic [15:0] FDPS_STEP_RESET = 16'h2b8c;
  // ramp tick is the system clock divided by four
  localparam int FDPS_RAMP_DIV = 4;
  localparam logic [1:0] FDPS_RAMP_LAST = 2'(FDPS_RAMP_DIV - 1);
  // phase adjustment keeps the sequencer busy for one cycle more than this count
  localparam logic [3:0] FDPS_ADJ_CYCLES = 4'h8;
  localparam int FDPS_ACC_W = 24;
  // ahb-lite codes
  localparam logic [1:0] FDPS_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] FDPS_HSIZE_WORD = 3'h2;
  typedef enum logic [1:0] {
    FDPS_ADJ_IDLE = 2'b00,
    FDPS_ADJ_BUSY = 2'b01
  } fdps_adj_t;
endpackage : fdps_pkg

// ### design/fdps_ctrl.sv
// Functional notes
// RULE1: writing apply-now 0->1 applies phase; bit self-clears when adjust completes
// RULE2: apply-on-sync set (reset 1): reapply phase on every divider sync
// RULE3: software sets low-rate flag when first stage below 70MHz
// RULE4: sync group code 0 group0, 1 group1, 2 and 3 none
// RULE5: phase is signed quarter-vco units; positive lags, negative leads
// RULE6: phase resets to -16, four vco periods lead
// RULE7: phase commits only when upper byte bits 9:8 written
// RULE8: spread bit 31 turns modulation on; shape, depth, step define it
// RULE9: with sharing, second divider ramp starts when first enable set
// RULE10: software enables second divider spread before the first
// RULE11: shape 0 down spread, 1 center spread
// RULE12: down mode: depth sets lower limit, upper limit zero
// RULE13: center mode swings depth each side
// RULE14: software encodes depth as percent/100 times 2^14
// RULE15: software sets step from depth, rate and 15MHz
// RULE16: ramp advances at system clock divided by four
// RULE17: software picks modulation rate 30kHz to 63kHz
// RULE18: depth resets 0x51, step resets 0x2b8c
// RULE19: software zeroes low six fraction bits with spread
// RULE20: writing 0, or 1 while busy, to apply-now does nothing
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module fdps_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // divider side
  input wire logic divider_sync,
  input wire logic share_start,
  input wire logic modulation_share,
  output logic [9:0] phase_offset,
  output logic phase_load,
  output logic slow_first_stage,
  output logic [1:0] group_sel,
  output logic group_none,
  output logic ramp_tick,
  output logic signed [8:0] modulation_offset,
  output logic modulation_on
);
  // address phase capture
  logic wr_pend;
  logic rd_pend;
  logic [7:0] addr_q;
  wire addr_ok = hsel && hready && htrans == fdps_pkg::FDPS_HTRANS_NONSEQ && hsize == fdps_pkg::FDPS_HSIZE_WORD;
  // decode from the captured address, shared by writes and reads
  wire sel_phase = addr_q == fdps_pkg::FDPS_PHASE_ADDR;
  wire sel_spread = addr_q == fdps_pkg::FDPS_SPREAD_ADDR;
  wire sel_status = addr_q == fdps_pkg::FDPS_STATUS_ADDR;
  wire wr_phase = wr_pend && sel_phase;
  wire wr_spread = wr_pend && sel_spread;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite;
      rd_pend <= addr_ok && !hwrite;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      addr_q <= 8'h00;
    end
    else
    begin
      addr_q <= haddr;
    end
  end

  // phase register
  logic apply_now;
  logic apply_sync;
  logic slow_en;
  logic [1:0] group;
  logic [9:0] phase;
  logic sync_pend;
  fdps_pkg::fdps_adj_t adj_state;
  logic [3:0] adj_cnt;
  // write data fields of the phase word
  wire wd_apply_now = hwdata[fdps_pkg::FDPS_APPLY_NOW_BIT];
  wire wd_apply_sync = hwdata[fdps_pkg::FDPS_APPLY_SYNC_BIT];
  wire wd_slow = hwdata[fdps_pkg::FDPS_SLOW_BIT];
  wire [1:0] wd_group = hwdata[fdps_pkg::FDPS_GROUP_HI:fdps_pkg::FDPS_GROUP_LO];
  wire [9:0] wd_phase = hwdata[fdps_pkg::FDPS_PHASE_HI:0];
  // full word write holds bits 9:8, so every write commits atomically
  wire phase_commit = wr_phase; // [RULE7]
  wire adj_idle = adj_state == fdps_pkg::FDPS_ADJ_IDLE;
  wire adj_busy = adj_state == fdps_pkg::FDPS_ADJ_BUSY;
  wire now_req = phase_commit && wd_apply_now && !apply_now; // [RULE1] [RULE20]
  // a sync that lands mid-adjust waits instead of being lost
  wire sync_req = (divider_sync || sync_pend) && apply_sync; // [RULE2]
  wire adj_start = (now_req || sync_req) && adj_idle;
  wire adj_done = adj_busy && adj_cnt == fdps_pkg::FDPS_ADJ_CYCLES;

  // held sync request, dropped if reapply is switched off
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync_pend <= 1'b0;
    end
    else
    begin
      sync_pend <= sync_req && !adj_idle; // [RULE2]
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      apply_sync <= fdps_pkg::FDPS_APPLY_SYNC_RESET;
      slow_en <= 1'b0;
      group <= fdps_pkg::FDPS_GROUP_RESET;
      phase <= fdps_pkg::FDPS_PHASE_RESET; // [RULE6]
    end
    else if (phase_commit)
    begin
      apply_sync <= wd_apply_sync;
      slow_en <= wd_slow;
      group <= wd_group;
      phase <= wd_phase;
    end
  end

  // adjustment sequencer; apply-now bit reads 1 until done
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      adj_state <= fdps_pkg::FDPS_ADJ_IDLE;
      adj_cnt <= 4'h0;
      apply_now <= 1'b0;
      phase_load <= 1'b0;
      phase_offset <= fdps_pkg::FDPS_PHASE_RESET;
    end
    else
    begin
      phase_load <= adj_start;
      unique case (adj_state)
        fdps_pkg::FDPS_ADJ_IDLE:
        begin
          adj_cnt <= 4'h0;
          if (adj_start)
          begin
            adj_state <= fdps_pkg::FDPS_ADJ_BUSY;
            apply_now <= now_req; // [RULE1]
            // new value from this very write is used if present
            phase_offset <= phase_commit ? wd_phase : phase; // [RULE5]
          end
        end
        fdps_pkg::FDPS_ADJ_BUSY:
        begin
          adj_cnt <= adj_cnt + 4'h1;
          if (adj_done)
          begin
            adj_state <= fdps_pkg::FDPS_ADJ_IDLE;
            apply_now <= 1'b0; // [RULE1]
          end
        end
      endcase
    end
  end

  // sync group decode
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      group_sel <= 2'h0;
      group_none <= 1'b0;
      slow_first_stage <= 1'b0;
    end
    else
    begin
      group_sel <= group;
      group_none <= group[1]; // [RULE4]
      slow_first_stage <= slow_en;
    end
  end

  // spread register
  logic ssc_en;
  logic ssc_center;
  logic [7:0] ampl;
  logic [15:0] step;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ssc_en <= 1'b0;
      ssc_center <= 1'b0;
    end
    else if (wr_spread)
    begin
      ssc_en <= hwdata[fdps_pkg::FDPS_SSC_EN_BIT];
      ssc_center <= hwdata[fdps_pkg::FDPS_SSC_MODE_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ampl <= fdps_pkg::FDPS_AMPL_RESET; // [RULE18]
      step <= fdps_pkg::FDPS_STEP_RESET; // [RULE18]
    end
    else if (wr_spread)
    begin
      ampl <= hwdata[fdps_pkg::FDPS_AMPL_HI:fdps_pkg::FDPS_AMPL_LO];
      step <= hwdata[fdps_pkg::FDPS_STEP_HI:0];
    end
  end

  // run gate: shared divider waits for the first divider's enable
  logic run;
  wire run_next = ssc_en && (!modulation_share || run || share_start); // [RULE8] [RULE9]
  // ramp tick divider
  logic [1:0] div_cnt;
  wire tick = div_cnt == fdps_pkg::FDPS_RAMP_LAST;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      run <= 1'b0;
    end
    else
    begin
      run <= run_next; // [RULE9]
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      div_cnt <= 2'h0;
      ramp_tick <= 1'b0;
    end
    else
    begin
      // ramp restarts phase-aligned on enable
      div_cnt <= run ? div_cnt + 2'h1 : 2'h0; // [RULE16]
      ramp_tick <= run && tick; // [RULE16]
    end
  end

  // triangle ramp; accumulator fraction units, depth scaled by 2^16
  logic [fdps_pkg::FDPS_ACC_W-1:0] acc;
  logic going_down;
  wire [fdps_pkg::FDPS_ACC_W-1:0] limit = {ampl, 16'h0000};
  // center mode spans twice the depth: 0..2*limit, then recentred
  wire [fdps_pkg::FDPS_ACC_W:0] span = ssc_center ? {limit, 1'b0} : {1'b0, limit}; // [RULE12] [RULE13]
  wire [fdps_pkg::FDPS_ACC_W:0] acc_up = {1'b0, acc} + {9'h000, step};
  wire up_hit = acc_up >= span;
  wire down_hit = acc <= {8'h00, step};
  always_ff @(posedge sys_clk)
  begin
    if (rst || !run)
    begin
      acc <= '0;
      going_down <= 1'b0;
    end
    else if (tick)
    begin
      if (!going_down)
      begin
        acc <= up_hit ? span[fdps_pkg::FDPS_ACC_W-1:0] : acc_up[fdps_pkg::FDPS_ACC_W-1:0];
        going_down <= up_hit;
      end
      else
      begin
        acc <= down_hit ? '0 : acc - {8'h00, step};
        going_down <= !down_hit;
      end
    end
  end

  // deviation out: down mode 0..-depth, center +depth..-depth
  wire signed [9:0] dev_mag = {2'b00, acc[fdps_pkg::FDPS_ACC_W-1:16]};
  wire signed [9:0] dev_ctr = dev_mag - {2'b00, ampl};
  wire signed [9:0] dev_val = ssc_center ? -dev_ctr : -dev_mag; // [RULE11]
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      modulation_offset <= 9'sh000;
      modulation_on <= 1'b0;
    end
    else
    begin
      modulation_offset <= run ? dev_val[8:0] : 9'sh000;
      modulation_on <= run;
    end
  end

  // read mux
  wire [31:0] phase_word = {16'h0000, apply_now, apply_sync, slow_en, 1'b0, group, phase};
  wire [31:0] spread_word = {ssc_en, ssc_center, 6'h00, ampl, step};
  wire [31:0] status_word = {30'h0, adj_busy, run};
  wire [31:0] rd_word = sel_phase ? phase_word :
    sel_spread ? spread_word :
    sel_status ? status_word : 32'h0000_0000;
  // read data loads only for a read, so it stands until the next read
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_pend)
    begin
      hrdata <= rd_word;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      // reads answered one cycle after the data phase opens
      hreadyout <= !(addr_ok && !hwrite);
      hresp <= 1'b0;
    end
  end
endmodule : fdps_ctrl
`default_nettype wire

// ### bench/fdps_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module fdps_ctrl_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hreadyout,
  input wire logic hresp,
  // divider side
  input wire logic [9:0] phase_offset,
  input wire logic phase_load,
  input wire logic [1:0] group_sel,
  input wire logic group_none,
  input wire logic ramp_tick,
  input wire logic modulation_on
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  wire take = hsel && hready && htrans == fdps_pkg::FDPS_HTRANS_NONSEQ && hsize == fdps_pkg::FDPS_HSIZE_WORD;
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  a_load_one_pulse: assert property (phase_load |=> !phase_load [*4])
    else $error("phase load repeated");
  a_phase_on_load: assert property ($changed(phase_offset) |-> phase_load || $past(phase_load))
    else $error("phase moved without load");
  a_group_none_code: assert property (group_none == group_sel[1])
    else $error("group none wrong");
  a_tick_spacing: assert property (ramp_tick |=> !ramp_tick [*3])
    else $error("ramp tick too close");
  a_tick_period: assert property (ramp_tick ##1 modulation_on [*4] |-> ramp_tick)
    else $error("ramp tick missing");
  // three cycles so a one-cycle lag of the status flag is tolerated
  a_no_tick_off: assert property (!modulation_on [*3] |-> !ramp_tick)
    else $error("ramp tick while off");
  c_read: cover property (take && !hwrite);
  c_load: cover property (phase_load);
  c_tick: cover property (ramp_tick && modulation_on);
endmodule : fdps_ctrl_props
bind fdps_ctrl fdps_ctrl_props props_u (.sys_clk, .rst, .hsel, .hready, .htrans, .hwrite, .hsize, .hreadyout,
  .hresp, .phase_offset, .phase_load, .group_sel, .group_none, .ramp_tick, .modulation_on);
`default_nettype wire

// ### bench/fdps_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("FAIL %0t mismatch %h %h", $time, a, b); end end
module fdps_ctrl_bench;
  localparam logic [7:0] ph_addr = fdps_pkg::FDPS_PHASE_ADDR;
  localparam logic [7:0] sp_addr = fdps_pkg::FDPS_SPREAD_ADDR;
  logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic divider_sync = 1'b0, share_start = 1'b0, modulation_share = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = fdps_pkg::FDPS_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0, rdata;
  logic [9:0] ph_m = 10'h3f0;
  wire logic [31:0] hrdata;
  wire hreadyout, hresp, phase_load, slow_first_stage, group_none, ramp_tick, modulation_on;
  wire logic [9:0] phase_offset;
  wire logic [1:0] group_sel;
  wire logic signed [8:0] modulation_offset;
  int failures = 0, check_count = 0, cycles = 0, loads = 0, ticks = 0, omin, omax;
  fdps_ctrl dut_u (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .divider_sync, .share_start, .modulation_share, .phase_offset, .phase_load,
    .slow_first_stage, .group_sel, .group_none, .ramp_tick, .modulation_offset, .modulation_on);
  initial
    forever #10 sys_clk = ~sys_clk;
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // one ahb-lite single transfer; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= fdps_pkg::FDPS_HTRANS_NONSEQ;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rdata = hrdata;
  endtask : bus
  // mid-cycle sampling keeps counts clear of the edge race
  always @(negedge sys_clk)
  begin
    cycles++;
    loads += int'(phase_load === 1'b1);
    ticks += int'(ramp_tick === 1'b1);
    if (modulation_offset < omin) omin = modulation_offset;
    if (modulation_offset > omax) omax = modulation_offset;
    if (cycles == 40000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  initial
  begin
    logic [31:0] e;
    int a, s;
    e = $urandom(32'hde8c);
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(1'b0, ph_addr, 32'h0); `CHK(rdata, 32'h43f0)
    `CHK(phase_offset, 10'h3f0)
    bus(1'b0, sp_addr, 32'h0); `CHK(rdata, 32'h00512b8c)
    bus(1'b0, 8'h0c, 32'h0); `CHK(rdata, 32'h0)
    // every group code, sync reapply on and off
    for (int i = 0; i < 8; i++)
    begin
      s = $urandom;
      e = {16'h0, 1'b0, i[2], s[10], 1'b0, i[1:0], s[9:0]};
      bus(1'b1, ph_addr, e);
      bus(1'b0, ph_addr, 32'h0); `CHK(rdata, e)
      `CHK({group_none, group_sel}, {e[11], e[11:10]})
      `CHK(slow_first_stage, e[13])
      a = loads;
      divider_sync <= 1'b1;
      @(posedge sys_clk);
      divider_sync <= 1'b0;
      repeat (12) @(posedge sys_clk);
      `CHK(loads - a, int'(e[14]))
      if (e[14]) ph_m = e[9:0];
      `CHK(phase_offset, ph_m)
    end
    s = $urandom;
    e = {16'h0, 6'h20, s[9:0]};
    a = loads;
    bus(1'b1, ph_addr, e);
    bus(1'b0, ph_addr, 32'h0); `CHK(rdata[15], 1'b1)
    bus(1'b0, 8'h08, 32'h0); `CHK(rdata, 32'h2)
    bus(1'b1, ph_addr, e ^ 32'h155);
    repeat (12) @(posedge sys_clk);
    `CHK(loads - a, 1)
    `CHK(phase_offset, e[9:0])
    bus(1'b0, ph_addr, 32'h0); `CHK(rdata[15], 1'b0)
    bus(1'b1, ph_addr, 32'h0);
    repeat (12) @(posedge sys_clk);
    `CHK(loads - a, 1)
    for (int m = 0; m < 2; m++)
    begin
      s = $urandom;
      e = {1'b1, m[0], 6'h0, 2'b01, s[5:0], 2'b11, s[29:16]};
      bus(1'b1, sp_addr, e);
      bus(1'b0, sp_addr, 32'h0); `CHK(rdata, e)
      omin = 1000;
      omax = -1000;
      a = ticks;
      repeat (3000) @(posedge sys_clk);
      `CHK(modulation_on, 1'b1)
      `CHK(ticks - a, 750)
      `CHK(omin, -int'(e[23:16]))
      `CHK(omax, m ? int'(e[23:16]) : 0)
      bus(1'b1, sp_addr, 32'h0);
      bus(1'b0, sp_addr, 32'h0); `CHK(modulation_on, 1'b0)
    end
    // second divider enabled before the first; fraction bits zeroed elsewhere
    modulation_share <= 1'b1;
    bus(1'b1, sp_addr, 32'h80512b8c);
    repeat (8) @(posedge sys_clk);
    `CHK(modulation_on, 1'b0)
    share_start <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK(modulation_on, 1'b1)
    share_start <= 1'b0;
    tally_and_finish();
  end
endmodule : fdps_ctrl_bench
`default_nettype wire
